// File: logic/viu_cmd_status.v
// Command, status and debug registers of a 32-source vectored interrupt unit
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Pending register shows one bit per source, fast bit0, platform bit1.
// - Enable mask readable, same layout, one means enabled, zero after reset.
// - Line status: bit0 fast request active, bit1 normal request active.
// - Enable command sets mask bits written as one, zeros unchanged.
// - Disable command clears mask bits written as one, zeros ignored.
// - Clear command clears pending bits written as one.
// - Set command forces pending bits written as one.
// - Any write to end-of-interrupt location ends current treatment.
// - Spurious vector is a 32-bit read/write register reset to zero.
// - Spurious vector is returned on normal or fast readback when spurious.
// - Debug control bit0 enables debugger-safe mode; resets to zero.
// - Debug control bit1 holds both core request lines inactive.
// - Fast-forcing enable command, bits 1 to 31, enables forcing per source.
`include "viu_map.vh"
module viu_cmd_status #(
  parameter NSRC = 32
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Interrupt sources (asynchronous, active high)
  input  wire [NSRC-1:0] srcIn,
  // Vectors from the arbitration logic
  input  wire [31:0] normVecIn,
  input  wire [31:0] fastVecIn,
  // Core request lines, active low
  output reg         coreFastLine_n,
  output reg         coreReqLine_n,
  // Forcing state to the arbitration logic
  output reg  [NSRC-1:0] fastForceMask,
  // Block event interrupt
  output reg         evtIrq
);

  // Synchroniser and edge state
  reg [NSRC-1:0] srcMeta_ff;
  reg [NSRC-1:0] srcSync_ff;
  reg [NSRC-1:0] srcPrev_ff;
  // Source state
  reg [NSRC-1:0] pend_ff;
  reg [NSRC-1:0] mask_ff;
  reg [NSRC-1:0] force_ff;
  reg            inSvc_ff;
  reg [31:0]     spurVec_ff;
  reg [1:0]      dbgCtrl_ff;
  reg [`VIU_EVT_W-1:0] evtStat_ff;
  reg [`VIU_EVT_W-1:0] evtMask_ff;
  // Bus data phase state
  reg                   wrPend_ff;
  reg [`VIU_ADDR_W-1:0] wrAddr_ff;

  reg [NSRC-1:0] nxt_pend;
  reg [NSRC-1:0] nxt_mask;
  reg [NSRC-1:0] nxt_force;
  reg            nxt_inSvc;
  reg [31:0]     nxt_spurVec;
  reg [1:0]      nxt_dbgCtrl;
  reg [`VIU_EVT_W-1:0] nxt_evtStat;
  reg [`VIU_EVT_W-1:0] nxt_evtMask;
  reg [31:0]     nxt_rdata;
  reg            nxt_fastLine;
  reg            nxt_reqLine;
  reg [`VIU_EVT_W-1:0] evtHit;

  // Address phase decode
  wire accept = hsel & hready & htrans[1];
  wire rdAcc  = accept & ~hwrite;
  wire wrAcc  = accept & hwrite;
  wire [`VIU_ADDR_W-1:0] rdAddr = haddr[`VIU_ADDR_W-1:0];
  wire [NSRC-1:0] srcRise = srcSync_ff & ~srcPrev_ff;

  // Write strobes, data phase
  wire wEn   = wrPend_ff && wrAddr_ff == `VIU_OFS_EN_CMD;
  wire wDis  = wrPend_ff && wrAddr_ff == `VIU_OFS_DIS_CMD;
  wire wClr  = wrPend_ff && wrAddr_ff == `VIU_OFS_CLR_CMD;
  wire wSet  = wrPend_ff && wrAddr_ff == `VIU_OFS_SET_CMD;
  wire wEoi  = wrPend_ff && wrAddr_ff == `VIU_OFS_EOI_CMD;
  wire wSpur = wrPend_ff && wrAddr_ff == `VIU_OFS_SPUR_VEC;
  wire wDbg  = wrPend_ff && wrAddr_ff == `VIU_OFS_DBG_CTRL;
  wire wFf   = wrPend_ff && wrAddr_ff == `VIU_OFS_FF_EN_CMD;
  wire wEvtM = wrPend_ff && wrAddr_ff == `VIU_OFS_EVT_MASK;
  // In safe mode the acknowledge moves from read to a write of the readback
  wire wCurV = wrPend_ff && wrAddr_ff == `VIU_OFS_CUR_VEC;

  // Active, enabled requests split into fast and normal paths
  wire [NSRC-1:0] live = pend_ff & mask_ff;
  wire fastReq = live[`VIU_BIT_FAST] | (|(live & force_ff));
  wire normReq = |(live & ~force_ff & `VIU_FF_WMASK);
  wire normSpur = ~normReq;
  wire fastSpur = ~fastReq;

  // Two-flop synchroniser; only the second stage feeds logic
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      srcMeta_ff <= {NSRC{1'b0}};
      srcSync_ff <= {NSRC{1'b0}};
      srcPrev_ff <= {NSRC{1'b0}};
    end else begin
      srcMeta_ff <= srcIn;
      srcSync_ff <= srcMeta_ff;
      srcPrev_ff <= srcSync_ff;
    end
  end

  // Next state of pending, mask, forcing and control
  always @* begin
    nxt_mask = mask_ff;
    if (wEn)
      nxt_mask = nxt_mask | hwdata[NSRC-1:0];
    if (wDis)
      nxt_mask = nxt_mask & ~hwdata[NSRC-1:0];
    // A source edge in the clearing cycle is kept: set wins over clear
    nxt_pend = pend_ff;
    if (wClr)
      nxt_pend = nxt_pend & ~hwdata[NSRC-1:0];
    nxt_pend = nxt_pend | srcRise;
    if (wSet)
      nxt_pend = nxt_pend | hwdata[NSRC-1:0];
    nxt_force = force_ff;
    if (wFf)
      nxt_force = force_ff | (hwdata[NSRC-1:0] & `VIU_FF_WMASK);
    nxt_spurVec = wSpur ? hwdata : spurVec_ff;
    nxt_dbgCtrl = wDbg ? hwdata[1:0] : dbgCtrl_ff;
    nxt_evtMask = wEvtM ? hwdata[`VIU_EVT_W-1:0] : evtMask_ff;
  end

  // Treatment tracking: readback (in safe mode a write of the readback) starts it, any end-of-interrupt write ends it
  always @* begin
    nxt_inSvc = inSvc_ff;
    if (!dbgCtrl_ff[`VIU_BIT_SAFE] && rdAcc && rdAddr == `VIU_OFS_CUR_VEC && normReq)
      nxt_inSvc = 1'b1;
    if (dbgCtrl_ff[`VIU_BIT_SAFE] && wCurV && normReq)
      nxt_inSvc = 1'b1;
    if (wEoi)
      nxt_inSvc = 1'b0;
  end

  // Core lines; the global mask parks both inactive
  always @* begin
    nxt_fastLine = fastReq;
    nxt_reqLine  = normReq & ~inSvc_ff;
    if (dbgCtrl_ff[`VIU_BIT_GMASK]) begin
      nxt_fastLine = 1'b0;
      nxt_reqLine  = 1'b0;
    end
  end

  // Sticky events: end-of-interrupt seen, spurious vector handed out
  always @* begin
    evtHit = {`VIU_EVT_W{1'b0}};
    evtHit[`VIU_EVT_EOI] = wEoi;
    if (rdAcc && rdAddr == `VIU_OFS_CUR_VEC && normSpur)
      evtHit[`VIU_EVT_SPUR] = 1'b1;
    if (rdAcc && rdAddr == `VIU_OFS_FAST_VEC && fastSpur)
      evtHit[`VIU_EVT_SPUR] = 1'b1;
    nxt_evtStat = evtStat_ff;
    if (rdAcc && rdAddr == `VIU_OFS_EVT_STAT)
      nxt_evtStat = {`VIU_EVT_W{1'b0}};
    // Set after clear so an event in the read cycle survives
    nxt_evtStat = nxt_evtStat | evtHit;
  end

  // Read mux, sampled in the address phase; command words read zero
  always @* begin
    nxt_rdata = `VIU_RST_WORD;
    case (rdAddr)
      `VIU_OFS_PEND:
        nxt_rdata[NSRC-1:0] = pend_ff;
      `VIU_OFS_MASK:
        nxt_rdata[NSRC-1:0] = mask_ff;
      `VIU_OFS_LINE_STAT: begin
        nxt_rdata[0] = ~coreFastLine_n;
        nxt_rdata[1] = ~coreReqLine_n;
      end
      `VIU_OFS_CUR_VEC:
        nxt_rdata = normSpur ? spurVec_ff : normVecIn;
      `VIU_OFS_FAST_VEC:
        nxt_rdata = fastSpur ? spurVec_ff : fastVecIn;
      `VIU_OFS_SPUR_VEC:
        nxt_rdata = spurVec_ff;
      `VIU_OFS_DBG_CTRL:
        nxt_rdata[1:0] = dbgCtrl_ff;
      `VIU_OFS_EVT_STAT:
        nxt_rdata[`VIU_EVT_W-1:0] = evtStat_ff;
      `VIU_OFS_EVT_MASK:
        nxt_rdata[`VIU_EVT_W-1:0] = evtMask_ff;
      default:
        nxt_rdata = `VIU_RST_WORD;
    endcase
  end

  // State registers
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pend_ff    <= {NSRC{1'b0}};
      mask_ff    <= {NSRC{1'b0}};
      force_ff   <= {NSRC{1'b0}};
      inSvc_ff   <= 1'b0;
      spurVec_ff <= `VIU_RST_WORD;
      dbgCtrl_ff <= 2'h0;
      evtStat_ff <= {`VIU_EVT_W{1'b0}};
      evtMask_ff <= {`VIU_EVT_W{1'b0}};
    end else begin
      pend_ff    <= nxt_pend;
      mask_ff    <= nxt_mask;
      force_ff   <= nxt_force;
      inSvc_ff   <= nxt_inSvc;
      spurVec_ff <= nxt_spurVec;
      dbgCtrl_ff <= nxt_dbgCtrl;
      evtStat_ff <= nxt_evtStat;
      evtMask_ff <= nxt_evtMask;
    end
  end

  // Bus slave: zero wait states, reads registered into the data phase.
  // A read right after a write sees the value from before that write.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= {`VIU_ADDR_W{1'b0}};
      hrdata    <= `VIU_RST_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_ff <= wrAcc;
      if (wrAcc)
        wrAddr_ff <= haddr[`VIU_ADDR_W-1:0];
      if (rdAcc)
        hrdata <= nxt_rdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Registered outputs; core lines are active low
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      coreFastLine_n <= 1'b1;
      coreReqLine_n  <= 1'b1;
      fastForceMask  <= {NSRC{1'b0}};
      evtIrq         <= 1'b0;
    end else begin
      coreFastLine_n <= ~nxt_fastLine;
      coreReqLine_n  <= ~nxt_reqLine;
      fastForceMask  <= nxt_force;
      evtIrq         <= |(nxt_evtStat & evtMask_ff);
    end
  end

endmodule // viu_cmd_status

// File: logic/viu_map.vh
// Register map and field constants of the interrupt command/status block
`ifndef VIU_MAP_VH
`define VIU_MAP_VH
`define VIU_OFS_CUR_VEC   12'h100
`define VIU_OFS_FAST_VEC  12'h104
`define VIU_OFS_PEND      12'h10C
`define VIU_OFS_MASK      12'h110
`define VIU_OFS_LINE_STAT 12'h114
`define VIU_OFS_EN_CMD    12'h120
`define VIU_OFS_DIS_CMD   12'h124
`define VIU_OFS_CLR_CMD   12'h128
`define VIU_OFS_SET_CMD   12'h12C
`define VIU_OFS_EOI_CMD   12'h130
`define VIU_OFS_SPUR_VEC  12'h134
`define VIU_OFS_DBG_CTRL  12'h138
`define VIU_OFS_FF_EN_CMD 12'h140
`define VIU_OFS_EVT_STAT  12'h150
`define VIU_OFS_EVT_MASK  12'h154
`define VIU_ADDR_W        12
`define VIU_BIT_FAST      0
`define VIU_BIT_PLAT      1
`define VIU_BIT_SAFE      0
`define VIU_BIT_GMASK     1
`define VIU_EVT_EOI       0
`define VIU_EVT_SPUR      1
`define VIU_EVT_W         2
`define VIU_FF_WMASK      32'hFFFFFFFE
`define VIU_RST_WORD      32'h00000000
`define VIU_HTRANS_NSEQ   2'h2
`define VIU_HTRANS_SEQ    2'h3
`endif

// File: tb/viu_core_model.sv
// Core-side model: watches both request lines and counts requests taken
`timescale 1ns/1ps
module viu_core_model (
  // Clock and reset
  input  wire       mclk,
  input  wire       rstn,
  // Request lines, active low
  input  wire       fastLine_n,
  input  wire       reqLine_n,
  // Requests seen
  output reg  [7:0] fastCnt,
  output reg  [7:0] reqCnt
);
  reg fastD_ff;
  reg reqD_ff;
  // A core takes a falling line as one new request; it never drives back
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {fastD_ff, reqD_ff, fastCnt, reqCnt} <= 18'h30000;
    end else begin
      {fastD_ff, reqD_ff} <= {fastLine_n, reqLine_n};
      fastCnt <= fastCnt + {7'h0, fastD_ff & ~fastLine_n};
      reqCnt  <= reqCnt + {7'h0, reqD_ff & ~reqLine_n};
    end
  end
endmodule // viu_core_model

// File: tb/viu_cmd_status_chk.sv
// Checker of register readback, line masking and forcing state
`timescale 1ns/1ps
`include "viu_map.vh"
module viu_cmd_status_chk #(
  parameter NSRC = 32
) (
  // Clock and reset
  input wire            mclk,
  input wire            rstn,
  // Bus
  input wire            hsel,
  input wire [31:0]     haddr,
  input wire [1:0]      htrans,
  input wire            hwrite,
  input wire            hready,
  input wire [31:0]     hwdata,
  input wire [31:0]     hrdata,
  // Core lines and forcing
  input wire            coreFastLine_n,
  input wire            coreReqLine_n,
  input wire [NSRC-1:0] fastForceMask
);
  reg        aV_ff, aW_ff;
  reg [11:0] aA_ff;
  reg [31:0] mask_ff, spur_ff, dbg_ff;
  wire       rPh = aV_ff & ~aW_ff;
  wire       wPh = aV_ff & aW_ff;
  // Shadow state; updates land at the data phase edge like the slave's
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {aV_ff, aW_ff, aA_ff, mask_ff, spur_ff, dbg_ff} <= 110'h0;
    end else begin
      {aV_ff, aW_ff, aA_ff} <= {hsel & hready & htrans[1], hwrite, haddr[11:0]};
      if (wPh && aA_ff == `VIU_OFS_EN_CMD) mask_ff <= mask_ff | hwdata;
      if (wPh && aA_ff == `VIU_OFS_DIS_CMD) mask_ff <= mask_ff & ~hwdata;
      if (wPh && aA_ff == `VIU_OFS_SPUR_VEC) spur_ff <= hwdata;
      if (wPh && aA_ff == `VIU_OFS_DBG_CTRL) dbg_ff <= hwdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_mask_readback: assert property (
    rPh && aA_ff == `VIU_OFS_MASK |-> hrdata == $past(mask_ff)) else $error("mask readback");
  a_spur_readback: assert property (
    rPh && aA_ff == `VIU_OFS_SPUR_VEC |-> hrdata == $past(spur_ff)) else $error("spur readback");
  a_dbg_readback: assert property (
    rPh && aA_ff == `VIU_OFS_DBG_CTRL |-> hrdata[1:0] == $past(dbg_ff[1:0]))
    else $error("debug readback");
  a_line_status: assert property (
    rPh && aA_ff == `VIU_OFS_LINE_STAT |->
    hrdata[1:0] == ~{$past(coreReqLine_n), $past(coreFastLine_n)}) else $error("line status");
  a_wo_read_zero: assert property (
    rPh && (aA_ff inside {[12'h120:12'h130], 12'h140}) |-> hrdata == 32'h0)
    else $error("write-only read not zero");
  a_gmask_quiet: assert property (
    dbg_ff[1] && $past(dbg_ff[1]) |-> coreFastLine_n && coreReqLine_n) else $error("line active");
  a_force_bit0: assert property (
    fastForceMask[0] == 1'b0) else $error("forcing on fast source");
  a_force_sticky: assert property (
    ($past(fastForceMask) & ~fastForceMask) == 0) else $error("forcing bit dropped");
  a_force_enable: assert property (
    wPh && aA_ff == `VIU_OFS_FF_EN_CMD |=>
    ((~fastForceMask & $past(hwdata[NSRC-1:0])) >> 1) == 0) else $error("forcing not set");
  c_gmask: cover property (dbg_ff[1] && $past(dbg_ff[1]));
  c_line_read: cover property (rPh && aA_ff == `VIU_OFS_LINE_STAT && hrdata[1]);
  c_force: cover property (wPh && aA_ff == `VIU_OFS_FF_EN_CMD);
endmodule // viu_cmd_status_chk
bind viu_cmd_status viu_cmd_status_chk #(.NSRC(NSRC)) u_chk (.mclk(mclk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .coreFastLine_n(coreFastLine_n),
  .coreReqLine_n(coreReqLine_n), .fastForceMask(fastForceMask));

// File: tb/viu_cmd_status_tb_top.sv
// Self-checking bench for the interrupt command/status block
`timescale 1ns/1ps
`include "viu_map.vh"
module viu_cmd_status_tb_top;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] srcIn = 32'h0;
  reg  [31:0] rd;
  wire [31:0] hrdata, ffMask;
  wire        hreadyout, hresp, fastN, reqN, evtIrq;
  wire [7:0]  fastCnt, reqCnt;
  integer     fail_count = 0;
  integer     tests_run = 0;
  integer     i;
  always #12.5 mclk = ~mclk;
  viu_cmd_status uut (.mclk(mclk), .rstn(rstn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .srcIn(srcIn),
    .normVecIn(32'h00000A00), .fastVecIn(32'h00000F00), .coreFastLine_n(fastN),
    .coreReqLine_n(reqN), .fastForceMask(ffMask), .evtIrq(evtIrq));
  viu_core_model core (.mclk(mclk), .rstn(rstn), .fastLine_n(fastN), .reqLine_n(reqN),
    .fastCnt(fastCnt), .reqCnt(reqCnt));
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for ready; a stuck bus ends the run
  task waitRdy;
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n == 50) begin
        fail_count = fail_count + 1;
        test_done;
      end
    end
  endtask
  // One single word transfer: address phase, then data phase
  task busOp(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      htrans <= `VIU_HTRANS_NSEQ;
      haddr <= {20'h0, a};
      hwrite <= w;
      waitRdy;
      htrans <= 2'h0;
      if (w) hwdata <= d;
      waitRdy;
      rd = hrdata;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      busOp(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  // Let synchronisers and registered lines settle, then look off the edge
  task settle;
    begin
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rdc(`VIU_OFS_PEND, 32'h0);
    rdc(`VIU_OFS_MASK, 32'h0);
    rdc(`VIU_OFS_LINE_STAT, 32'h0);
    rdc(`VIU_OFS_DBG_CTRL, 32'h0);
    rdc(`VIU_OFS_SPUR_VEC, 32'h0);
    busOp(1'b1, `VIU_OFS_SPUR_VEC, 32'hCAFE1234);
    busOp(1'b1, `VIU_OFS_EVT_MASK, 32'h3);
    rdc(`VIU_OFS_CUR_VEC, 32'hCAFE1234);
    rdc(`VIU_OFS_FAST_VEC, 32'hCAFE1234);
    settle;
    chk({31'h0, evtIrq}, 32'h1);
    rdc(`VIU_OFS_EVT_STAT, 32'h2);
    settle;
    chk({31'h0, evtIrq}, 32'h0);
    // Enable, enable, then disable with zeros elsewhere
    busOp(1'b1, `VIU_OFS_EN_CMD, 32'h5);
    busOp(1'b1, `VIU_OFS_EN_CMD, 32'h2);
    busOp(1'b1, `VIU_OFS_DIS_CMD, 32'h1);
    rdc(`VIU_OFS_MASK, 32'h6);
    busOp(1'b1, `VIU_OFS_SET_CMD, 32'h4);
    settle;
    rdc(`VIU_OFS_LINE_STAT, 32'h2);
    busOp(1'b1, `VIU_OFS_DBG_CTRL, 32'h2);
    settle;
    chk({30'h0, fastN, reqN}, 32'h3);
    rdc(`VIU_OFS_DBG_CTRL, 32'h2);
    busOp(1'b1, `VIU_OFS_DBG_CTRL, 32'h0);
    // Command locations read as zero and leave state alone
    for (i = 0; i < 5; i = i + 1)
      rdc(12'(`VIU_OFS_EN_CMD + 4 * i), 32'h0);
    rdc(`VIU_OFS_FF_EN_CMD, 32'h0);
    rdc(`VIU_OFS_MASK, 32'h6);
    rdc(`VIU_OFS_PEND, 32'h4);
    // Handler takes the vector, then signals the end with a masked event
    busOp(1'b1, `VIU_OFS_EVT_MASK, 32'h2);
    rdc(`VIU_OFS_CUR_VEC, 32'h00000A00);
    settle;
    chk({31'h0, reqN}, 32'h1);
    busOp(1'b1, `VIU_OFS_EOI_CMD, 32'h5A5A0000);
    settle;
    chk({31'h0, evtIrq}, 32'h0);
    busOp(1'b1, `VIU_OFS_EVT_MASK, 32'h3);
    settle;
    chk({31'h0, evtIrq}, 32'h1);
    rdc(`VIU_OFS_EVT_STAT, 32'h1);
    busOp(1'b1, `VIU_OFS_CLR_CMD, 32'h4);
    srcIn <= 32'h8;
    settle;
    rdc(`VIU_OFS_PEND, 32'h8);
    chk({31'h0, |reqCnt}, 32'h1);
    busOp(1'b1, `VIU_OFS_EN_CMD, 32'h1);
    busOp(1'b1, `VIU_OFS_SET_CMD, 32'h1);
    settle;
    chk({30'h0, fastN, |fastCnt}, 32'h1);
    rdc(`VIU_OFS_FAST_VEC, 32'h00000F00);
    // Safe mode: the readback does not start treatment; only a write to it starts treatment
    busOp(1'b1, `VIU_OFS_SET_CMD, 32'h4);
    busOp(1'b1, `VIU_OFS_DBG_CTRL, 32'h1);
    rdc(`VIU_OFS_DBG_CTRL, 32'h1);
    rdc(`VIU_OFS_CUR_VEC, 32'h00000A00);
    settle;
    chk({31'h0, reqN}, 32'h0);
    busOp(1'b1, `VIU_OFS_CUR_VEC, 32'h0);
    settle;
    chk({31'h0, reqN}, 32'h1);
    busOp(1'b1, `VIU_OFS_EOI_CMD, 32'h0);
    busOp(1'b1, `VIU_OFS_DBG_CTRL, 32'h0);
    settle;
    chk({31'h0, reqN}, 32'h0);
    busOp(1'b1, `VIU_OFS_FF_EN_CMD, 32'hFFFFFFFF);
    settle;
    chk(ffMask, 32'hFFFFFFFE);
    test_done;
  end
endmodule // viu_cmd_status_tb_top
